// file: src/pdl_consts.svh
// Offsets, field positions, reset values and timing counts of the PHY bank
// What this block does
// R1 - Read-only diagnostic register 0x12, reset 0x0000, last negotiation.
// R2 - Writable transmit gain register at 0x13, reset 0x4000.
// R3 - LED source register 0x17, reset 0x0010, picks both LED sources.
// R4 - Bits 7:4 select the second LED source, reset 0x1, activity.
// R5 - Bits 3:0 select the first LED source, reset 0x0, link good.
// R6 - Code 0x0 gives link good, 0x8 link good blinking; 0x2-0x4 reserved.
// R7 - Code 0x5 gives 100 Mb/s, 0x6 gives 10 Mb/s, 0x7 gives full duplex.
// R8 - Crossover register 0x18, reset 0x00c0, governs MDI/MDIX mux.
// R9 - Negotiation failure flag sets on no common ability, clears on read.
// R10 - All registers reachable and pollable over management interface.
`ifndef PDL_CONSTS_SVH
`define PDL_CONSTS_SVH

`define PDL_ADDR_DIAG      5'h12
`define PDL_ADDR_GAIN      5'h13
`define PDL_ADDR_LED       5'h17
`define PDL_ADDR_XOVR      5'h18

`define PDL_RST_DIAG       16'h0000
`define PDL_RST_GAIN       16'h4000
`define PDL_RST_LED        8'h10
`define PDL_RST_XOVR       16'h00c0

`define PDL_DIAG_FAIL      12
`define PDL_DIAG_DUPLEX    11
`define PDL_DIAG_RATE      10
`define PDL_DIAG_RXSIG     9
`define PDL_DIAG_RXLOCK    8

`define PDL_LED_SEL_W      4
`define PDL_LED_LINK       4'h0
`define PDL_LED_ACT        4'h1
`define PDL_LED_RSV_LO     4'h2
`define PDL_LED_RSV_HI     4'h4
`define PDL_LED_100        4'h5
`define PDL_LED_10         4'h6
`define PDL_LED_FDX        4'h7
`define PDL_LED_BLINK      4'h8

`define PDL_PRE_LEN        6'h20
`define PDL_OP_RD          2'h2
`define PDL_OP_WR          2'h1
`define PDL_CMD_LAST       5'h0b
`define PDL_RD_LAST        5'h11
`define PDL_WR_FIRST       5'h02
`define PDL_WR_LAST        5'h11

`define PDL_BLINK_MS       50
`define PDL_CLK_KHZ        250000
`define PDL_BLINK_CYCLES   (`PDL_BLINK_MS * `PDL_CLK_KHZ)

`endif

// file: src/pdl_pkg.sv
// Types shared by the PHY diagnostic and LED register bank
package pdl_pkg;
   typedef enum logic [2:0] {
      ST_PRE,
      ST_START,
      ST_CMD,
      ST_RD,
      ST_WR
   } pdl_state_e;
endpackage : pdl_pkg

// file: src/pdl_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pdl_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_in,   // System clock
   input  wire logic rst_in,   // Async reset, high
   input  wire logic d_in,     // Asynchronous pin level
   output logic      q_out     // Filtered level
);
   logic s1;
   logic s2;
   logic s3;
   logic next_q;

   // Level moves only when the last two stages agree, so a metastable
   // settle in the second stage never reaches the frame logic
   always_comb begin
      next_q = (s2 == s3) ? s2 : q_out;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1    <= RST_VAL;
         s2    <= RST_VAL;
         s3    <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         s1    <= d_in;
         s2    <= s1;
         s3    <= s2;
         q_out <= next_q;
      end
   end
endmodule : pdl_sync

// file: src/pdl_regs.sv
// PHY diagnostic, gain, LED and crossover registers behind the MDIO slave
`timescale 1ns/10ps
`include "pdl_consts.svh"
module pdl_regs
   import pdl_pkg::*;
#(
   parameter logic [4:0]  PHY_ADDR     = 5'h00,
   parameter int unsigned BLINK_CYCLES = `PDL_BLINK_CYCLES
) (
   input  wire logic        MCLK_IN,          // System clock, 250 MHz
   input  wire logic        SYS_RST_IN,       // Async reset, high
   input  wire logic        MDC_IN,           // Management clock pin
   input  wire logic        MDIO_IN,          // Management data pin in
   output logic             MDIO_OUT,         // Management data pin out
   output logic             MDIO_OE_OUT,      // High while driving data
   input  wire logic        LINK_OK_IN,       // Link good status
   input  wire logic        ACTIVITY_IN,      // Receive or transmit busy
   input  wire logic        SPEED100_IN,      // 100 Mb/s mode
   input  wire logic        SPEED10_IN,       // 10 Mb/s mode
   input  wire logic        FULL_DUPLEX_IN,   // Full-duplex operation
   input  wire logic        AUTONEG_FAIL_IN,  // Pulse, no common ability
   input  wire logic        ANEG_DUPLEX_IN,   // Negotiated full duplex
   input  wire logic        ANEG_RATE_IN,     // Negotiated 100 Mb/s
   input  wire logic        RX_SIGNAL_IN,     // Receive signal detected
   input  wire logic        RX_LOCK_IN,       // Receive PLL locked
   output logic [1:0]       LED_OUT,          // LED drives, high is on
   output logic [15:0]      TX_GAIN_OUT,      // Transmit gain setting
   output logic [15:0]      XOVER_CTRL_OUT    // Crossover mux control
);
   logic        mdc_s;
   logic        mdio_s;
   logic        mdc_q;
   logic        rise;
   pdl_state_e  state;
   pdl_state_e  next_state;
   logic [5:0]  pre_cnt;
   logic [5:0]  next_pre_cnt;
   logic [4:0]  cnt;
   logic [4:0]  next_cnt;
   logic [15:0] sh;
   logic [15:0] next_sh;
   logic [4:0]  reg_a;
   logic [4:0]  next_reg_a;
   logic        next_mdio;
   logic        next_oe;
   logic        wr_stb;
   logic        rd_diag;
   logic [15:0] wr_data;
   logic [4:0]  cmd_reg;
   logic [4:0]  cmd_phy;
   logic [1:0]  cmd_op;
   logic        ours;
   logic        fail_flag;
   logic        next_fail_flag;
   logic [3:0]  stat;
   logic [3:0]  next_stat;
   logic [7:0]  led_cfg;
   logic [7:0]  next_led_cfg;
   logic [15:0] next_gain;
   logic [15:0] next_xovr;
   logic [31:0] blink_cnt;
   logic [31:0] next_blink_cnt;
   logic        blink_ph;
   logic        next_blink_ph;
   logic [1:0]  next_led;
   logic [15:0] diag_val;
   localparam logic [15:0] DIAG_RST = `PDL_RST_DIAG;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   pdl_sync #(.RST_VAL(1'b0)) u_mdc_sync (
      .clk_in (MCLK_IN),
      .rst_in (SYS_RST_IN),
      .d_in   (MDC_IN),
      .q_out  (mdc_s)
   );

   pdl_sync #(.RST_VAL(1'b1)) u_mdio_sync (
      .clk_in (MCLK_IN),
      .rst_in (SYS_RST_IN),
      .d_in   (MDIO_IN),
      .q_out  (mdio_s)
   );

   assign rise    = mdc_s & ~mdc_q;
   assign wr_data = {sh[14:0], mdio_s};
   assign cmd_op  = sh[10:9];
   assign cmd_phy = sh[8:4];
   assign cmd_reg = {sh[3:0], mdio_s};
   assign ours    = (cmd_phy == PHY_ADDR) &&
                    ((cmd_reg == `PDL_ADDR_DIAG) ||
                     (cmd_reg == `PDL_ADDR_GAIN) ||
                     (cmd_reg == `PDL_ADDR_LED) ||
                     (cmd_reg == `PDL_ADDR_XOVR));

   // R1 diagnostic word
   assign diag_val = {3'h0, fail_flag, stat, 8'h00};

   // Management frame: preamble, start, op, addresses, turnaround, data.
   // Addresses outside this bank are left undriven for the rest of the PHY.
   always_comb begin
      next_state   = state;
      next_pre_cnt = pre_cnt;
      next_cnt     = cnt;
      next_sh      = sh;
      next_reg_a   = reg_a;
      next_mdio    = MDIO_OUT;
      next_oe      = MDIO_OE_OUT;
      wr_stb       = 1'b0;
      rd_diag      = 1'b0;
      if (rise) begin
         case (state)
            ST_PRE: begin
               if (mdio_s) begin
                  if (pre_cnt != `PDL_PRE_LEN) begin
                     next_pre_cnt = pre_cnt + 6'h01;
                  end
               end else begin
                  if (pre_cnt == `PDL_PRE_LEN) begin
                     next_state = ST_START;
                  end
                  next_pre_cnt = 6'h00;
               end
            end
            ST_START: begin
               next_cnt   = 5'h00;
               next_state = mdio_s ? ST_CMD : ST_PRE;
            end
            ST_CMD: begin
               next_sh  = wr_data;
               next_cnt = cnt + 5'h01;
               if (cnt == `PDL_CMD_LAST) begin
                  next_cnt   = 5'h00;
                  next_reg_a = cmd_reg;
                  next_state = ST_PRE;
                  // R10 only a matching address answers
                  if (ours && cmd_op == `PDL_OP_RD) begin
                     next_state = ST_RD;
                     if (cmd_reg == `PDL_ADDR_DIAG) begin
                        next_sh = diag_val;
                        rd_diag = 1'b1;
                     end else if (cmd_reg == `PDL_ADDR_GAIN) begin
                        next_sh = TX_GAIN_OUT;
                     end else if (cmd_reg == `PDL_ADDR_LED) begin
                        next_sh = {8'h00, led_cfg};
                     end else begin
                        next_sh = XOVER_CTRL_OUT;
                     end
                  end else if (ours && cmd_op == `PDL_OP_WR) begin
                     next_state = ST_WR;
                  end
               end
            end
            ST_RD: begin
               next_cnt = cnt + 5'h01;
               if (cnt == 5'h00) begin
                  next_oe   = 1'b1;
                  next_mdio = 1'b0;
               end else if (cnt == `PDL_RD_LAST) begin
                  next_oe    = 1'b0;
                  next_mdio  = 1'b0;
                  next_state = ST_PRE;
               end else begin
                  next_mdio = sh[15];
                  next_sh   = {sh[14:0], 1'b0};
               end
            end
            ST_WR: begin
               next_cnt = cnt + 5'h01;
               if (cnt >= `PDL_WR_FIRST) begin
                  next_sh = wr_data;
               end
               if (cnt == `PDL_WR_LAST) begin
                  wr_stb     = 1'b1;
                  next_state = ST_PRE;
               end
            end
            default: begin
               next_state = ST_PRE;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         mdc_q       <= 1'b0;
         state       <= ST_PRE;
         pre_cnt     <= 6'h00;
         cnt         <= 5'h00;
         sh          <= 16'h0000;
         reg_a       <= 5'h00;
         MDIO_OUT    <= 1'b0;
         MDIO_OE_OUT <= 1'b0;
      end else begin
         mdc_q       <= mdc_s;
         state       <= next_state;
         pre_cnt     <= next_pre_cnt;
         cnt         <= next_cnt;
         sh          <= next_sh;
         reg_a       <= next_reg_a;
         MDIO_OUT    <= next_mdio;
         MDIO_OE_OUT <= next_oe;
      end
   end

   // Register contents; the diagnostic word has no write path
   always_comb begin
      // R9 a new failure wins over the clearing read
      next_fail_flag = AUTONEG_FAIL_IN | (fail_flag & ~rd_diag);
      next_stat      = {ANEG_DUPLEX_IN, ANEG_RATE_IN,
                        RX_SIGNAL_IN, RX_LOCK_IN};
      next_gain      = TX_GAIN_OUT;
      next_led_cfg   = led_cfg;
      next_xovr      = XOVER_CTRL_OUT;
      if (wr_stb) begin
         // R2 gain write
         if (reg_a == `PDL_ADDR_GAIN) begin
            next_gain = wr_data;
         // R3 LED source write, upper byte reads as zero
         end else if (reg_a == `PDL_ADDR_LED) begin
            next_led_cfg = wr_data[7:0];
         // R8 crossover write
         end else if (reg_a == `PDL_ADDR_XOVR) begin
            next_xovr = wr_data;
         end
      end
   end

   always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         fail_flag      <= DIAG_RST[`PDL_DIAG_FAIL];
         stat           <= DIAG_RST[`PDL_DIAG_DUPLEX:`PDL_DIAG_RXLOCK];
         TX_GAIN_OUT    <= `PDL_RST_GAIN;
         led_cfg        <= `PDL_RST_LED;
         XOVER_CTRL_OUT <= `PDL_RST_XOVR;
      end else begin
         fail_flag      <= next_fail_flag;
         stat           <= next_stat;
         TX_GAIN_OUT    <= next_gain;
         led_cfg        <= next_led_cfg;
         XOVER_CTRL_OUT <= next_xovr;
      end
   end

   // Blink phase toggles every BLINK_CYCLES while the counter runs free
   always_comb begin
      next_blink_cnt = blink_cnt + 32'h00000001;
      next_blink_ph  = blink_ph;
      if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
         next_blink_cnt = 32'h00000000;
         next_blink_ph  = ~blink_ph;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_led
         logic [3:0] sel;
         logic       led_nx;
         assign sel = led_cfg[gi*`PDL_LED_SEL_W +: `PDL_LED_SEL_W];
         // R4 R5 R6 R7 source decode, reserved codes keep the LED off
         always_comb begin
            case (sel)
               `PDL_LED_LINK:  led_nx = LINK_OK_IN;
               `PDL_LED_ACT:   led_nx = ACTIVITY_IN;
               `PDL_LED_100:   led_nx = SPEED100_IN;
               `PDL_LED_10:    led_nx = SPEED10_IN;
               `PDL_LED_FDX:   led_nx = FULL_DUPLEX_IN;
               `PDL_LED_BLINK: led_nx = LINK_OK_IN & ~(ACTIVITY_IN & blink_ph);
               default:        led_nx = 1'b0;
            endcase
         end
         assign next_led[gi] = led_nx;
      end
   endgenerate

   always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         blink_cnt <= 32'h00000000;
         blink_ph  <= 1'b0;
         LED_OUT   <= 2'h0;
      end else begin
         blink_cnt <= next_blink_cnt;
         blink_ph  <= next_blink_ph;
         LED_OUT   <= next_led;
      end
   end

   sequence s_ta_edge;
      state == ST_RD && rise && cnt == 5'h00;
   endsequence
   sequence s_ta_drive;
      MDIO_OE_OUT && !MDIO_OUT;
   endsequence

   a_fail_set: assert property (AUTONEG_FAIL_IN |=> fail_flag) // R9
      else $error("failure flag not set");
   a_fail_clear: assert property ( // R9
      rd_diag && !AUTONEG_FAIL_IN |=> !fail_flag)
      else $error("failure flag not cleared by read");
   a_diag_read: assert property ( // R1
      rd_diag |=> sh == {3'h0, $past(fail_flag), $past(stat), 8'h00})
      else $error("diagnostic word wrong");
   a_gain_write: assert property ( // R2
      wr_stb && reg_a == `PDL_ADDR_GAIN |=> TX_GAIN_OUT == $past(wr_data))
      else $error("gain write lost");
   a_led_write: assert property ( // R3
      wr_stb && reg_a == `PDL_ADDR_LED |=> led_cfg == $past(wr_data[7:0]))
      else $error("LED source write lost");
   a_xovr_write: assert property ( // R8
      wr_stb && reg_a == `PDL_ADDR_XOVR |=> XOVER_CTRL_OUT == $past(wr_data))
      else $error("crossover write lost");
   a_led_second_act: assert property ( // R4
      led_cfg[7:4] == `PDL_LED_ACT |=> LED_OUT[1] == $past(ACTIVITY_IN))
      else $error("second LED not following activity");
   a_led_first_link: assert property ( // R5
      led_cfg[3:0] == `PDL_LED_LINK |=> LED_OUT[0] == $past(LINK_OK_IN))
      else $error("first LED not following link");
   a_led_reserved: assert property ( // R6
      led_cfg[3:0] >= `PDL_LED_RSV_LO && led_cfg[3:0] <= `PDL_LED_RSV_HI
      |=> !LED_OUT[0])
      else $error("reserved LED code lit the LED");
   a_led_speed: assert property ( // R7
      led_cfg[3:0] == `PDL_LED_100 |=> LED_OUT[0] == $past(SPEED100_IN))
      else $error("first LED not following 100 Mb/s mode");
   a_read_turn: assert property (s_ta_edge |=> s_ta_drive) // R10
      else $error("turnaround zero not driven");
   a_read_release: assert property ( // R10
      state == ST_RD && rise && cnt == `PDL_RD_LAST |=> !MDIO_OE_OUT)
      else $error("data pin not released");
endmodule : pdl_regs

// file: tb/pdl_sta.sv
// Management station model driving MDC and MDIO frames at the PHY bank
`timescale 1ns/10ps
module pdl_sta #(
   parameter int HALF = 20
) (
   input  wire logic clk_in,   // System clock
   input  wire logic pin_in,   // Resolved data pin level
   output logic      mdc_out,  // Management clock, still between frames
   output logic      drv_out,  // Level driven on the data pin
   output logic      en_out    // High while the station drives
);
   initial begin
      mdc_out = 1'b0;
      drv_out = 1'b1;
      en_out  = 1'b0;
   end

   // Data set while MDC is low, held through the high phase
   task automatic bit_cyc(input logic en, input logic v, output logic s);
      @(negedge clk_in);
      en_out  = en;
      drv_out = v;
      repeat (HALF) @(negedge clk_in);
      s       = pin_in;
      mdc_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
      mdc_out = 1'b0;
   endtask : bit_cyc

   // every frame carries preamble, start, op, addresses
   task automatic xfer(input logic wr, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [16:0] rd);
      logic [45:0] hdr;
      logic [17:0] sh;
      logic        s;
      hdr = {32'hffffffff, 2'b01, (wr ? 2'b01 : 2'b10), phy, ra};
      sh  = 18'h00000;
      for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      if (wr) begin
         bit_cyc(1'b1, 1'b1, s);
         bit_cyc(1'b1, 1'b0, s);
         for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wd[i], s);
      end else begin
         // Released from turnaround on; the pull-up shows if nobody answers
         for (int i = 0; i < 18; i++) begin
            bit_cyc(1'b0, 1'b1, s);
            sh = {sh[16:0], s};
         end
      end
      @(negedge clk_in);
      en_out = 1'b0;
      rd     = sh[16:0];
   endtask : xfer
endmodule : pdl_sta

// file: tb/tb_top.sv
// Self-checking bench for the PHY diagnostic, gain, LED and crossover bank
`timescale 1ns/10ps
`include "pdl_consts.svh"
module tb_top;
   localparam logic [4:0] PHY = 5'h00;
   logic        mclk, rst, mdc, sta_drv, sta_en, mdio_pin, mdio_out, mdio_oe;
   logic        a_fail, a_dup, a_rate, rx_sig, rx_lock;
   logic [4:0]  st;
   logic [1:0]  led;
   logic [15:0] gain, xover;
   logic [16:0] rd;
   logic [3:0]  ca, cb;
   int          err_count, tests_run, cyc, ones;

   // Open-drain style data pin with pull-up
   assign mdio_pin = mdio_oe ? mdio_out : (sta_en ? sta_drv : 1'b1);

   pdl_regs #(.PHY_ADDR(PHY), .BLINK_CYCLES(8)) uut (
      .MCLK_IN(mclk), .SYS_RST_IN(rst), .MDC_IN(mdc), .MDIO_IN(mdio_pin),
      .MDIO_OUT(mdio_out), .MDIO_OE_OUT(mdio_oe), .LINK_OK_IN(st[4]),
      .ACTIVITY_IN(st[3]), .SPEED100_IN(st[2]), .SPEED10_IN(st[1]),
      .FULL_DUPLEX_IN(st[0]), .AUTONEG_FAIL_IN(a_fail),
      .ANEG_DUPLEX_IN(a_dup), .ANEG_RATE_IN(a_rate), .RX_SIGNAL_IN(rx_sig),
      .RX_LOCK_IN(rx_lock), .LED_OUT(led), .TX_GAIN_OUT(gain),
      .XOVER_CTRL_OUT(xover));

   pdl_sta sta (.clk_in(mclk), .pin_in(mdio_pin), .mdc_out(mdc),
                .drv_out(sta_drv), .en_out(sta_en));

   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   task automatic end_sim();
      $display("Checks run %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // About 30 frames of 64 MDC periods at 41 cycles each
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [16:0] e,
                      input logic [16:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rd_reg(input logic [4:0] ra, input logic [16:0] e,
                         input string nm);
      sta.xfer(1'b0, PHY, ra, 16'h0000, rd);
      chk(nm, e, rd);
   endtask : rd_reg

   task automatic wr_reg(input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd);
      logic [16:0] dummy;
      sta.xfer(1'b1, phy, ra, wd, dummy);
   endtask : wr_reg

   // Blink code is only predictable with activity low or link down
   function automatic logic led_exp(input logic [3:0] c, input logic [4:0] s);
      case (c)
         4'h0: return s[4];
         4'h1: return s[3];
         4'h5: return s[2];
         4'h6: return s[1];
         4'h7: return s[0];
         4'h8: return s[4] & ~s[3];
         default: return 1'b0;
      endcase
   endfunction : led_exp

   task automatic set_st(input logic [4:0] v);
      @(negedge mclk);
      st = v;
      repeat (3) @(negedge mclk);
   endtask : set_st

   initial begin
      {err_count, tests_run, cyc} = '0;
      rst = 1'b1;
      st  = 5'h00;
      {a_fail, a_dup, a_rate, rx_sig, rx_lock} = 5'h00;
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      repeat (8) @(negedge mclk);
      rd_reg(`PDL_ADDR_DIAG, 17'h00000, "diag_reset");
      rd_reg(`PDL_ADDR_GAIN, 17'h04000, "gain_reset");
      rd_reg(`PDL_ADDR_LED, 17'h00010, "led_reset");
      rd_reg(`PDL_ADDR_XOVR, 17'h000c0, "xovr_reset");
      chk("gain_port_reset", 17'h04000, {1'b0, gain});
      chk("xovr_port_reset", 17'h000c0, {1'b0, xover});
      set_st(5'b10000);
      chk("led_default_link", 17'h00001, {15'h0, led});
      set_st(5'b01000);
      chk("led_default_act", 17'h00002, {15'h0, led});
      for (int c = 0; c < 10; c++) begin
         ca = 4'(c);
         cb = 4'(9 - c);
         wr_reg(PHY, `PDL_ADDR_LED, {8'h00, cb, ca});
         for (int p = 0; p < 2; p++) begin
            set_st(p == 0 ? 5'b10110 : 5'b01001);
            chk("led_code", {15'h0, led_exp(cb, st), led_exp(ca, st)},
                {15'h0, led});
         end
      end
      wr_reg(PHY, `PDL_ADDR_LED, 16'h0008);
      set_st(5'b11000);
      ones = 0;
      repeat (24) begin
         @(negedge mclk);
         ones += int'(led[0] === 1'b1);
      end
      chk("led_blinks", 17'h00001, {16'h0, ones > 0 && ones < 24});
      wr_reg(PHY, `PDL_ADDR_LED, 16'hab21);
      rd_reg(`PDL_ADDR_LED, 17'h00021, "led_high_byte");
      wr_reg(PHY, `PDL_ADDR_GAIN, 16'ha5c3);
      rd_reg(`PDL_ADDR_GAIN, 17'h0a5c3, "gain_rw");
      chk("gain_port", 17'h0a5c3, {1'b0, gain});
      wr_reg(PHY, `PDL_ADDR_XOVR, 16'h3c5a);
      rd_reg(`PDL_ADDR_XOVR, 17'h03c5a, "xovr_rw");
      chk("xovr_port", 17'h03c5a, {1'b0, xover});
      wr_reg(PHY, `PDL_ADDR_DIAG, 16'hffff);
      rd_reg(`PDL_ADDR_DIAG, 17'h00000, "diag_readonly");
      wr_reg(5'h01, `PDL_ADDR_GAIN, 16'h0000);
      rd_reg(`PDL_ADDR_GAIN, 17'h0a5c3, "other_phy_write");
      sta.xfer(1'b0, 5'h01, `PDL_ADDR_GAIN, 16'h0000, rd);
      chk("other_phy_read", 17'h1ffff, rd);
      @(negedge mclk);
      a_dup  = 1'b1;
      rx_sig = 1'b1;
      a_fail = 1'b1;
      @(negedge mclk);
      a_fail = 1'b0;
      rd_reg(`PDL_ADDR_DIAG, 17'h01a00, "diag_fail_set");
      rd_reg(`PDL_ADDR_DIAG, 17'h00a00, "diag_fail_clear");
      // Mid-run reset must bring written registers back to their defaults
      @(negedge mclk);
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (8) @(negedge mclk);
      chk("gain_port_rerst", 17'h04000, {1'b0, gain});
      chk("xovr_port_rerst", 17'h000c0, {1'b0, xover});
      rd_reg(`PDL_ADDR_LED, 17'h00010, "led_rerst");
      rd_reg(`PDL_ADDR_GAIN, 17'h04000, "gain_rerst");
      end_sim();
   end
endmodule : tb_top
